/* timer_option_overflow_ctrl_tb_top.sv */
`timescale 1ns/1ps
module timer_option_overflow_ctrl_tb_top;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, bop = 0, run = 0, wrap = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00, rdata;
  logic [2:0] bs = 3'h0, role;
  logic wirq, irq;
  int error_cnt = 0, n_checks = 0;
  tmopt_top dut (.MCLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wd),
    .WR(wr), .RD(rd), .BIT_OP(bop), .BIT_SEL(bs),
    .COUNTER_RUN_ENABLE(run), .COUNTER_WRAP(wrap), .RDATA(rdata),
    .CAPTURE_ROLE(role), .WRAP_IRQ_REQUEST(wirq), .IRQ(irq));
  initial forever #5 clk = ~clk;
  task cmp(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [7:0] d,
    input logic b);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    bop <= b;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1;
  endtask
  task rdc(input logic [3:0] a, input logic b, input logic [7:0] e);
    acc(0, a, 8'h00, b);
    cmp(rdata, e);
  endtask
  task pulse;
    @(posedge clk);
    wrap <= 1;
    @(posedge clk);
    wrap <= 0;
  endtask
  task close_out;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    wt(3);
    rdc(4'h0, 0, 8'h00);
    run <= 1;
    acc(1, 4'h0, 8'hFF, 0);
    rdc(4'h0, 0, 8'h20);
    for (int m = 0; m < 8; m++) begin
      acc(1, 4'h3, 8'(m), 0);
      wt(3);
      cmp({5'h00, role}, m == 5 ? 8'h02 : m == 6 ? 8'h07 : 8'h00);
    end
    pulse;
    #1;
    cmp({7'h00, wirq}, 8'h01);
    rdc(4'h0, 0, 8'h21);
    rdc(4'h0, 1, 8'h01);
    acc(1, 4'h0, 8'h00, 1);
    rdc(4'h0, 0, 8'h20);
    pulse;
    run <= 0;
    rdc(4'h0, 0, 8'h20);
    run <= 1;
    cmp({7'h00, irq}, 8'h00);
    acc(1, 4'h2, 8'h01, 0);
    wt(2);
    cmp({7'h00, irq}, 8'h01);
    acc(1, 4'h1, 8'h01, 0);
    wt(2);
    cmp({7'h00, irq}, 8'h00);
    rdc(4'hF, 0, 8'h00);
    close_out;
  end
  initial begin
    #20000;
    error_cnt++;
    close_out;
  end
endmodule // timer_option_overflow_ctrl_tb_top
bind tmopt_top tmopt_asserts chk (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR),
  .WR(WR), .RD(RD), .BIT_OP(BIT_OP), .COUNTER_RUN_ENABLE(COUNTER_RUN_ENABLE),
  .COUNTER_WRAP(COUNTER_WRAP), .RDATA(RDATA), .CAPTURE_ROLE(CAPTURE_ROLE),
  .WRAP_IRQ_REQUEST(WRAP_IRQ_REQUEST), .IRQ(IRQ));

/* tmopt_asserts.sv */
`timescale 1ns/1ps
module tmopt_asserts (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [3:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic BIT_OP,
  input wire logic COUNTER_RUN_ENABLE,
  input wire logic COUNTER_WRAP,
  input wire logic [7:0] RDATA,
  input wire logic [2:0] CAPTURE_ROLE,
  input wire logic WRAP_IRQ_REQUEST,
  input wire logic IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  wire rd0 = RD && ADDR == 4'h0 && !BIT_OP;
  wire run = COUNTER_RUN_ENABLE;
  chk_opt_rsvd_zero: assert property (
    $past(rd0) |-> (RDATA & 8'hDE) == 8'h00) else $error("rsvd bit set");
  chk_idle_rdata_zero: assert property (
    !$past(RD) |-> RDATA == 8'h00) else $error("rdata not idle");
  chk_bit_read_lsb: assert property (
    $past(RD && BIT_OP) |-> RDATA[7:1] == 7'h00) else $error("bit read");
  chk_unmapped_zero: assert property (
    $past(RD && ADDR > 4'h3) |-> RDATA == 8'h00) else $error("unmapped");
  chk_wrap_sets_flag: assert property (
    COUNTER_WRAP && run ##1 !WR && run ##1 rd0 && run |=> RDATA[0])
    else $error("flag not set");
  chk_disable_clears: assert property (
    !run ##1 rd0 |=> !RDATA[0]) else $error("flag not cleared");
  chk_irq_req_cause: assert property (
    WRAP_IRQ_REQUEST |-> $past(COUNTER_WRAP && run)) else $error("irq req");
  chk_role_pw_all: assert property (
    CAPTURE_ROLE[0] |-> CAPTURE_ROLE == 3'h7) else $error("role mix");
  cover property (WRAP_IRQ_REQUEST);
  cover property (IRQ);
  cover property (CAPTURE_ROLE == 3'h2);
endmodule // tmopt_asserts

/* tmopt_chsel.sv */
`timescale 1ns/1ps
module tmopt_chsel
  import tmopt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire tmopt_mode_t mode,
  input wire logic [2:0] sel_bits,
  output logic [2:0] capture_role
);
  // role per channel from mode
  function automatic logic role_of(input tmopt_mode_t m, input logic s);
    case (m)
      TMOPT_MD_FREERUN: role_of = s;
      TMOPT_MD_PULSEW: role_of = 1'b1;
      default: role_of = 1'b0;
    endcase
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_role <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        capture_role[i] <= role_of(mode, sel_bits[i]);
      end
    end
  end
endmodule // tmopt_chsel

/* tmopt_params.svh */
`ifndef TMOPT_PARAMS_SVH
`define TMOPT_PARAMS_SVH
`define TMOPT_ADDR_W 4
`define TMOPT_OFS_OPT 4'h0
`define TMOPT_OFS_IST 4'h1
`define TMOPT_OFS_IMSK 4'h2
`define TMOPT_OFS_MODE 4'h3
`define TMOPT_OPT_RST 8'h00
`define TMOPT_OPT_WMASK 8'h21
`define TMOPT_BIT_WRAP 0
`define TMOPT_BIT_CCS1 5
`define TMOPT_BIT_CCS0 4
`define TMOPT_BIT_CCS2 6
`define TMOPT_IRQ_RST 8'h00
`define TMOPT_MODE_RST 8'h00
`define TMOPT_MODE_W 3
`define TMOPT_RD_IDLE 8'h00
`endif

/* tmopt_pkg.sv */
package tmopt_pkg;
  typedef enum logic [2:0] {
    TMOPT_MD_INTERVAL = 3'h0,
    TMOPT_MD_EVENT = 3'h1,
    TMOPT_MD_TRIGPULSE = 3'h2,
    TMOPT_MD_ONESHOT = 3'h3,
    TMOPT_MD_PWM = 3'h4,
    TMOPT_MD_FREERUN = 3'h5,
    TMOPT_MD_PULSEW = 3'h6,
    TMOPT_MD_TRIPWM = 3'h7
  } tmopt_mode_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_op;
    logic [2:0] bit_sel;
    logic [3:0] addr;
    logic [7:0] wdata;
  } tmopt_req_t;
endpackage

/* tmopt_top.sv */
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`include "tmopt_params.svh"
// Operation
// - option register is eight bits; of its channel capture/compare selects only CCS1 (bit 5) is writable, CCS0 and CCS2 stay zero.
// - option register also shows sticky counter overflow flag.
// - byte and single-bit reads and writes both work correctly.
// - reset clears the whole option register to zero.
// - channel select bit acts only in free-running mode.
// - pulse-width mode captures only; free-running mode follows the select bits; other modes compare only.
module tmopt_top
  import tmopt_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [`TMOPT_ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic BIT_OP,
  input wire logic [2:0] BIT_SEL,
  input wire logic COUNTER_RUN_ENABLE,
  input wire logic COUNTER_WRAP,
  output logic [7:0] RDATA,
  output logic [2:0] CAPTURE_ROLE,
  output logic WRAP_IRQ_REQUEST,
  output logic IRQ
);
  logic rst_s1_reg;
  logic rst_n_reg;
  logic [7:0] opt_reg;
  logic [7:0] ist_reg;
  logic [7:0] imsk_reg;
  logic [7:0] mode_reg;
  logic [7:0] rdata_reg;
  logic wrap_irq_reg;
  logic irq_reg;
  logic wrap_irq_next;
  logic irq_next;
  logic wrap_ev;
  logic wr_opt;
  logic wr_ist;
  logic wr_imsk;
  logic wr_mode;
  tmopt_mode_t mode_cur;
  tmopt_req_t req;

  // merge a bit op into a byte
  function automatic logic [7:0] merge(input logic [7:0] old,
      input tmopt_req_t r);
    logic [7:0] v;
    v = old;
    if (r.bit_op) begin
      v[r.bit_sel] = r.wdata[0];
    end else begin
      v = r.wdata;
    end
    merge = v;
  endfunction

  // write hit on one offset
  function automatic logic hit(input tmopt_req_t r,
      input logic [`TMOPT_ADDR_W-1:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  // write-one-clear mask of a request
  function automatic logic [7:0] clr_mask(input tmopt_req_t r);
    logic [7:0] m;
    m = r.wdata;
    if (r.bit_op) begin
      m = 8'h00;
      m[r.bit_sel] = r.wdata[0];
    end
    clr_mask = m;
  endfunction

  // reset release sync
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  assign req = '{wr: WR, rd: RD, bit_op: BIT_OP, bit_sel: BIT_SEL,
                 addr: ADDR, wdata: WDATA};
  assign wrap_ev = COUNTER_WRAP && COUNTER_RUN_ENABLE;

  // register write decode
  assign wr_opt = hit(req, `TMOPT_OFS_OPT);
  assign wr_ist = hit(req, `TMOPT_OFS_IST);
  assign wr_imsk = hit(req, `TMOPT_OFS_IMSK);
  assign wr_mode = hit(req, `TMOPT_OFS_MODE);
  // current timer mode
  assign mode_cur = tmopt_mode_t'(mode_reg[`TMOPT_MODE_W-1:0]);

  // option register
  always_ff @(posedge MCLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      opt_reg <= `TMOPT_OPT_RST;
    end else begin
      logic [7:0] nv;
      nv = opt_reg;
      if (wr_opt) begin
        nv = merge(opt_reg, req);
        nv = (nv & `TMOPT_OPT_WMASK) | (opt_reg & ~`TMOPT_OPT_WMASK);
        nv[`TMOPT_BIT_WRAP] = opt_reg[`TMOPT_BIT_WRAP]
                              & nv[`TMOPT_BIT_WRAP];
      end
      if (!COUNTER_RUN_ENABLE) begin
        nv[`TMOPT_BIT_WRAP] = 1'b0;
      end
      if (wrap_ev) begin
        nv[`TMOPT_BIT_WRAP] = 1'b1;
      end
      opt_reg <= nv;
    end
  end

  // mode register
  always_ff @(posedge MCLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mode_reg <= `TMOPT_MODE_RST;
    end else if (wr_mode) begin
      mode_reg <= merge(mode_reg, req);
    end
  end

  // interrupt mask
  always_ff @(posedge MCLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      imsk_reg <= `TMOPT_IRQ_RST;
    end else if (wr_imsk) begin
      imsk_reg <= merge(imsk_reg, req);
    end
  end

  // sticky status, write one clears
  always_ff @(posedge MCLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ist_reg <= `TMOPT_IRQ_RST;
    end else begin
      logic [7:0] s;
      s = ist_reg;
      if (wr_ist) begin
        s = s & ~clr_mask(req);
      end
      if (wrap_ev) begin
        s[`TMOPT_BIT_WRAP] = 1'b1;
      end
      ist_reg <= s;
    end
  end

  // readback
  always_ff @(posedge MCLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_reg <= `TMOPT_RD_IDLE;
    end else if (req.rd) begin
      logic [7:0] v;
      case (req.addr)
        `TMOPT_OFS_OPT: v = opt_reg;
        `TMOPT_OFS_IST: v = ist_reg;
        `TMOPT_OFS_IMSK: v = imsk_reg;
        `TMOPT_OFS_MODE: v = mode_reg;
        default: v = 8'h00;
      endcase
      rdata_reg <= req.bit_op ? {7'h00, v[req.bit_sel]} : v;
    end else begin
      rdata_reg <= `TMOPT_RD_IDLE;
    end
  end

  // overflow request in all modes except free-running and pulse-width
  always_comb begin
    wrap_irq_next = wrap_ev;
    if (mode_cur == TMOPT_MD_FREERUN || mode_cur == TMOPT_MD_PULSEW) begin
      wrap_irq_next = 1'b0;
    end
    irq_next = |(ist_reg & imsk_reg);
  end

  // overflow request pulse
  always_ff @(posedge MCLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wrap_irq_reg <= 1'b0;
    end else begin
      wrap_irq_reg <= wrap_irq_next;
    end
  end

  // level interrupt
  always_ff @(posedge MCLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  tmopt_chsel u_chsel (
    .clk(MCLK),
    .rst_n(rst_n_reg),
    .mode(mode_cur),
    .sel_bits({opt_reg[`TMOPT_BIT_CCS2], opt_reg[`TMOPT_BIT_CCS1],
               opt_reg[`TMOPT_BIT_CCS0]}),
    .capture_role(CAPTURE_ROLE)
  );

  assign RDATA = rdata_reg;
  assign WRAP_IRQ_REQUEST = wrap_irq_reg;
  assign IRQ = irq_reg;
endmodule // tmopt_top
